// *** dv/host_model.sv ***
/*
 * Host processor model driving the 8-bit parallel bus pins.
 * Assumes the register map answers within the strobe timing below.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host bus model
// ****************************************
module host_model
(
	input  wire logic       clk_i,
	input  wire logic [7:0] data_o,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [2:0] addr_o,
	output logic      [7:0] wdata_o
);
	// Idle pins at time zero
	initial
	begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 3'h0;
		wdata_o = 8'ha5;
	end

	// Strobe low four edges, high five: above the three-cycle minimum
	task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		addr_o <= a;
		wdata_o <= d;
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		wdata_o <= ~d; // Released bus shows no stale byte
		repeat (5) @(posedge clk_i);
	endtask

	// Data is taken at the last edge before the strobe lifts
	task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		addr_o <= a;
		repeat (5) @(posedge clk_i);
		d = data_o;
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

// *** dv/register_map_chk.sv ***
/*
 * Port checker for the UART register map, bound to its top module.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Checker
// ****************************************
module register_map_chk
	import uart_regs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       rd_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic [7:0] data_o,
	input  wire logic       data_oe_n_o,
	input  wire logic [7:0] line_control_o,
	input  wire logic [7:0] enhanced_feature_o,
	input  wire logic [7:0] interrupt_enable_o,
	input  wire logic [7:0] modem_control_o,
	input  wire logic [7:0] queue_control_o,
	input  wire logic [7:0] baud_divisor_low_o,
	input  wire logic [7:0] resume_char_one_o,
	input  wire logic [7:0] extra_feature_o,
	input  wire logic       transmit_write_o
);
	logic rd_act;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Pin-level read strobe, before the synchroniser
	assign rd_act = !cs_n_i && !rd_n_i;

	// Read strobe steps as seen through the three-edge lag
	sequence s_read4;
		rd_act [*4];
	endsequence
	sequence s_idle3;
		!rd_act [*3];
	endsequence
	sequence s_rx4;
		(rd_act && addr_i == OFS_HOLD && !line_control_o[7]) [*4];
	endsequence

	property p_oe_drive;
		s_read4 |-> !data_oe_n_o;
	endproperty
	property p_oe_release;
		s_idle3 |=> data_oe_n_o;
	endproperty
	property p_idle_zero;
		data_oe_n_o |-> data_o == BYTE_ZERO;
	endproperty
	property p_rx_data;
		s_rx4 |-> data_o == $past(rx_data_i);
	endproperty
	property p_tx_pulse;
		transmit_write_o |-> !line_control_o[7] ##1 !transmit_write_o;
	endproperty
	// Two cycles of margin; the clear lands on the same edge as the enable write
	property p_gate;
		!enhanced_feature_o[4] && !$past(enhanced_feature_o[4])
			&& !$past(enhanced_feature_o[4], 2)
			|-> (interrupt_enable_o & INTEN_EXT_MASK) == BYTE_ZERO
			&& (modem_control_o & MCTL_EXT_MASK) == BYTE_ZERO
			&& (queue_control_o & QCTL_EXT_MASK) == BYTE_ZERO;
	endproperty
	property p_div_guard;
		!$stable(baud_divisor_low_o) |-> $past(line_control_o[7])
			&& $past(line_control_o) != ENH_PAGE_KEY;
	endproperty
	property p_enh_guard;
		!$stable(resume_char_one_o)
			|-> $past(line_control_o) == ENH_PAGE_KEY;
	endproperty
	property p_xfr_guard;
		!$stable(extra_feature_o) |-> !$past(line_control_o[7])
			&& $past(enhanced_feature_o[4]);
	endproperty

	a_oe_drive: assert property (p_oe_drive)
		else $error("read strobe not answered");
	a_oe_release: assert property (p_oe_release)
		else $error("bus not released");
	a_idle_zero: assert property (p_idle_zero)
		else $error("data not zero when idle");
	a_rx_data: assert property (p_rx_data)
		else $error("receive byte not returned");
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("transmit pulse wrong");
	a_gate: assert property (p_gate)
		else $error("gated bits set while disabled");
	a_div_guard: assert property (p_div_guard)
		else $error("divisor changed outside its page");
	a_enh_guard: assert property (p_enh_guard)
		else $error("flow char changed outside its page");
	a_xfr_guard: assert property (p_xfr_guard)
		else $error("extra feature changed while locked");
endmodule

bind uart_register_map register_map_chk i_chk
(
	.clk_i, .rst_n_i, .cs_n_i, .rd_n_i, .addr_i, .rx_data_i, .data_o,
	.data_oe_n_o, .line_control_o, .enhanced_feature_o,
	.interrupt_enable_o, .modem_control_o, .queue_control_o,
	.baud_divisor_low_o, .resume_char_one_o, .extra_feature_o,
	.transmit_write_o
);

`default_nettype wire

// *** dv/uart_register_map_tb.sv ***
/*
 * Self-checking bench for the UART register map: table of accesses,
 * then reset and gating cases.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Testbench
// ****************************************
module uart_register_map_tb
	import uart_regs_pkg::*;
;
	typedef struct packed
	{
		logic [7:0] lctl;
		logic [2:0] a;
		logic       w;
		logic [7:0] d;
		logic [7:0] e;
	} row_type;

	// Status inputs: f1, 60, c3; receive byte 9e
	localparam row_type rows [23] = '{
		'{8'h00, 3'h7, 1'b1, 8'h5a, 8'h5a}, '{8'h00, 3'h1, 1'b1, 8'hff, 8'h0f},
		'{8'h00, 3'h4, 1'b1, 8'hff, 8'h1f}, '{8'h00, 3'h2, 1'b1, 8'hff, 8'hc1},
		'{8'h00, 3'h6, 1'b1, 8'h55, 8'h03}, '{8'h00, 3'h5, 1'b1, 8'h3c, 8'h60},
		'{8'h00, 3'h0, 1'b1, 8'h77, 8'h9e}, '{8'h80, 3'h0, 1'b0, 8'h00, 8'h01},
		'{8'h80, 3'h1, 1'b0, 8'h00, 8'h5a}, '{8'h80, 3'h0, 1'b1, 8'h12, 8'h12},
		'{8'h80, 3'h1, 1'b1, 8'h34, 8'h34}, '{8'h80, 3'h3, 1'b0, 8'h00, 8'h80},
		'{8'h80, 3'h7, 1'b1, 8'h66, 8'h00}, '{8'hbf, 3'h4, 1'b1, 8'h11, 8'h11},
		'{8'hbf, 3'h7, 1'b1, 8'h22, 8'h22}, '{8'hbf, 3'h0, 1'b1, 8'hff, 8'h00},
		'{8'hbf, 3'h2, 1'b1, 8'h10, 8'h10}, '{8'h00, 3'h1, 1'b1, 8'hff, 8'hff},
		'{8'h00, 3'h4, 1'b1, 8'hff, 8'hff}, '{8'h00, 3'h2, 1'b0, 8'h00, 8'hf1},
		'{8'h00, 3'h6, 1'b1, 8'h55, 8'hc3}, '{8'h00, 3'h5, 1'b1, 8'h3c, 8'h60},
		'{8'h00, 3'h7, 1'b0, 8'h00, 8'h5a}};

	logic       clk_i, rst_n_i, cs_n, rd_n, wr_n, oe_n;
	logic [2:0] addr;
	logic [7:0] wdata, data_o, got, int_en, enh_feat, extra, ir_width;
	logic [7:0] tx_hold;
	logic       rx_rd, is_rd, ls_rd, ms_rd, qc_wr;
	logic [7:0] n_rx = 8'h00, n_is = 8'h00, n_ls = 8'h00;
	logic [7:0] n_ms = 8'h00, n_qc = 8'h00;
	int         miscompares = 0;
	int         cmp_count = 0;

	// Clock at 200 MHz
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	host_model i_host
	(
		.clk_i   (clk_i),
		.data_o  (data_o),
		.cs_n_o  (cs_n),
		.rd_n_o  (rd_n),
		.wr_n_o  (wr_n),
		.addr_o  (addr),
		.wdata_o (wdata)
	);

	uart_register_map i_dut
	(
		.clk_i (clk_i), .rst_n_i (rst_n_i), .cs_n_i (cs_n),
		.rd_n_i (rd_n), .wr_n_i (wr_n), .addr_i (addr),
		.data_i (wdata), .data_o (data_o), .data_oe_n_o (oe_n),
		.rx_data_i (8'h9e), .int_status_i (8'hf1),
		.line_status_i (8'h60), .modem_status_i (8'hc3),
		.interrupt_enable_o (int_en), .queue_control_o (),
		.line_control_o (), .modem_control_o (), .scratch_pad_o (),
		.baud_divisor_low_o (), .baud_divisor_high_o (),
		.enhanced_feature_o (enh_feat), .resume_char_one_o (),
		.resume_char_two_o (), .pause_char_one_o (),
		.pause_char_two_o (), .extra_feature_o (extra),
		.infrared_pulse_width_o (ir_width),
		.transmit_holding_o (tx_hold),
		.transmit_write_o (), .queue_control_write_o (qc_wr),
		.receive_read_o (rx_rd), .int_status_read_o (is_rd),
		.line_status_read_o (ls_rd), .modem_status_read_o (ms_rd)
	);

	// Access pulses last one cycle, so each one is counted once
	always @(posedge clk_i)
	begin
		n_rx <= n_rx + {7'h00, rx_rd};
		n_is <= n_is + {7'h00, is_rd};
		n_ls <= n_ls + {7'h00, ls_rd};
		n_ms <= n_ms + {7'h00, ms_rd};
		n_qc <= n_qc + {7'h00, qc_wr};
	end

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		#1;
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Reset four cycles
	task automatic do_reset;
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask

	// A hang costs far more than the roughly 750 cycles of the run
	initial
	begin
		#100000;
		miscompares++;
		end_of_test();
	end

	initial
	begin
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk("oe after reset", 8'h01, {7'h0, oe_n});
		foreach (rows[i])
		begin
			i_host.write_reg(OFS_LCTL, rows[i].lctl);
			if (rows[i].w)
				i_host.write_reg(rows[i].a, rows[i].d);
			i_host.read_reg(rows[i].a, got);
			chk("row read", rows[i].e, got);
		end
		chk("extra feature", 8'h3c, extra);
		chk("pulse width", 8'h55, ir_width);
		chk("transmit byte", 8'h77, tx_hold);
		chk("receive reads", 8'h01, n_rx);
		chk("int status reads", 8'h02, n_is);
		chk("line status reads", 8'h02, n_ls);
		chk("modem status reads", 8'h02, n_ms);
		chk("queue writes", 8'h01, n_qc);
		$display("table test done");
		// Mid-run reset, then locked extra feature write
		do_reset();
		chk("int enable reset", 8'h00, int_en);
		chk("enh feature reset", 8'h00, enh_feat);
		i_host.write_reg(OFS_LCTL, 8'h00);
		i_host.write_reg(3'h5, 8'h3c);
		chk("locked extra feature", 8'h00, extra);
		$display("reset test done");
		// Dropping the enable bit clears stored extended bits
		i_host.write_reg(OFS_LCTL, ENH_PAGE_KEY);
		i_host.write_reg(OFS_ENH, 8'h10);
		i_host.write_reg(OFS_LCTL, 8'h00);
		i_host.write_reg(OFS_INTEN, 8'hff);
		chk("int enable on", 8'hff, int_en);
		i_host.write_reg(OFS_LCTL, ENH_PAGE_KEY);
		i_host.write_reg(OFS_ENH, 8'h00);
		i_host.write_reg(OFS_LCTL, 8'h00);
		i_host.read_reg(OFS_INTEN, got);
		chk("int enable after disable", 8'h0f, got);
		$display("gating test done");
		end_of_test();
	end
endmodule

`default_nettype wire

// *** rtl/host_pins_if.sv ***
/*
 * Carrier for the host bus pins after synchronisation.
 * Assumes one clock; the source side is the pin synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none

interface host_pins_if;
	logic       sel;    // Chip selected
	logic       rd;     // Read strobe active
	logic       wr;     // Write strobe active
	logic [2:0] addr;
	logic [7:0] data;

	modport source
	(
		output sel, rd, wr, addr, data
	);
	modport sink
	(
		input  sel, rd, wr, addr, data
	);
endinterface

`default_nettype wire

// *** rtl/pin_sync.sv ***
/*
 * Two-flop synchroniser for the asynchronous host bus pins; the
 * active-low strobes are turned to active-high at the output of the second stage.
 * Assumes the pins are stable long enough to be seen at 200 MHz.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync
	import uart_regs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [PIN_W-1:0]  pins_i,
	host_pins_if.source            bus
);

	logic [PIN_W-1:0] stage_one;
	logic [PIN_W-1:0] stage_two;

	// Only the second stage reads the first one
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		stage_one <= {3'h7, 11'h000};
		stage_two <= {3'h7, 11'h000};
	end
	else
	begin
		stage_one <= pins_i;
		stage_two <= stage_one;
	end

	// Pin order: cs_n, rd_n, wr_n, addr[2:0], data[7:0]
	assign bus.sel  = ~stage_two[13];
	assign bus.rd   = ~stage_two[12];
	assign bus.wr   = ~stage_two[11];
	assign bus.addr = stage_two[10:8];
	assign bus.data = stage_two[7:0];

endmodule

`default_nettype wire

// *** rtl/uart_register_map.sv ***
/*
 * Address decode and register map of an 8-bit-bus UART: base page,
 * divisor page and enhanced page, with enhanced-gated fields.
 * Assumes the serial core sits on the same clock and supplies the
 * receive byte and the status bytes; host pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module uart_register_map
	import uart_regs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Host bus pins
	input  wire logic        cs_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_n_o,
	// From the serial core
	input  wire logic [7:0]  rx_data_i,
	input  wire logic [7:0]  int_status_i,
	input  wire logic [7:0]  line_status_i,
	input  wire logic [7:0]  modem_status_i,
	// Register contents towards the serial core
	output logic      [7:0]  interrupt_enable_o,
	output logic      [7:0]  queue_control_o,
	output logic      [7:0]  line_control_o,
	output logic      [7:0]  modem_control_o,
	output logic      [7:0]  scratch_pad_o,
	output logic      [7:0]  baud_divisor_low_o,
	output logic      [7:0]  baud_divisor_high_o,
	output logic      [7:0]  enhanced_feature_o,
	output logic      [7:0]  resume_char_one_o,
	output logic      [7:0]  resume_char_two_o,
	output logic      [7:0]  pause_char_one_o,
	output logic      [7:0]  pause_char_two_o,
	output logic      [7:0]  extra_feature_o,
	output logic      [7:0]  infrared_pulse_width_o,
	// Transmit byte and access pulses towards the serial core
	output logic      [7:0]  transmit_holding_o,
	output logic             transmit_write_o,
	output logic             queue_control_write_o,
	output logic             receive_read_o,
	output logic             int_status_read_o,
	output logic             line_status_read_o,
	output logic             modem_status_read_o
);

	// ************************************************************
	// Pin synchronisation
	// ************************************************************
	host_pins_if pins ();

	pin_sync u_pin_sync
	(
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pins_i  ({cs_n_i, rd_n_i, wr_n_i, addr_i, data_i}),
		.bus     (pins.source)
	);

	// ************************************************************
	// Register state
	// ************************************************************
	logic [7:0] int_en, q_ctl, line_ctl, mdm_ctl, scratch;
	logic [7:0] div_lo, div_hi, enh_feat, extra, ir_width;
	logic [7:0] res_one, res_two, pau_one, pau_two;

	// Strobe tracking
	logic       wr_act_q, rd_act_q;
	logic [2:0] wr_addr_q;
	logic [7:0] wr_data_q;

	// ************************************************************
	// Strobe decode
	// ************************************************************
	logic wr_act, rd_act, wr_commit, rd_start;

	// A write is taken when its strobe ends, so data is settled by then
	assign wr_act    = pins.sel & pins.wr;
	assign rd_act    = pins.sel & pins.rd;
	assign wr_commit = wr_act_q & ~wr_act;
	assign rd_start  = rd_act & ~rd_act_q;

	// ************************************************************
	// Page decode
	// ************************************************************
	logic base_page, div_page, enh_page, ext_on, div_zero;

	assign base_page = ~line_ctl[DIV_ACCESS_BIT];
	assign enh_page  = (line_ctl == ENH_PAGE_KEY);
	assign div_page  = line_ctl[DIV_ACCESS_BIT] & ~enh_page;
	assign ext_on    = enh_feat[ENH_ENABLE_BIT];
	assign div_zero  = (div_lo == BYTE_ZERO)
	                 & (div_hi == BYTE_ZERO);

	// ************************************************************
	// Write decode
	// ************************************************************
	logic [7:0] wr_hit;
	logic       wr_tx_hold, wr_div_lo, wr_div_hi, wr_int_en, wr_q_ctl;
	logic       wr_enh_feat, wr_line_ctl, wr_mdm_ctl, wr_res_one;
	logic       wr_extra, wr_res_two, wr_ir_width, wr_pau_one;
	logic       wr_scratch, wr_pau_two;

	// One-hot location of the write being committed, in the cycle after its strobe ends
	assign wr_hit      = wr_commit ? (8'h01 << wr_addr_q) : 8'h00;
	assign wr_tx_hold  = wr_hit[OFS_HOLD] & base_page;
	assign wr_div_lo   = wr_hit[OFS_DIV_LOW] & div_page;
	assign wr_div_hi   = wr_hit[OFS_DIV_HIGH] & div_page;
	assign wr_int_en   = wr_hit[OFS_INTEN] & base_page;
	assign wr_q_ctl    = wr_hit[OFS_INTST] & base_page;
	assign wr_enh_feat = wr_hit[OFS_ENH] & enh_page;
	assign wr_line_ctl = wr_hit[OFS_LCTL];
	assign wr_mdm_ctl  = wr_hit[OFS_MCTL] & base_page;
	assign wr_res_one  = wr_hit[OFS_RESUME_ONE] & enh_page;
	assign wr_extra    = wr_hit[OFS_LSTAT] & base_page & ext_on;
	assign wr_res_two  = wr_hit[OFS_RESUME_TWO] & enh_page;
	assign wr_ir_width = wr_hit[OFS_MSTAT] & base_page & ext_on;
	assign wr_pau_one  = wr_hit[OFS_PAUSE_ONE] & enh_page;
	assign wr_scratch  = wr_hit[OFS_SCRATCH] & base_page;
	assign wr_pau_two  = wr_hit[OFS_PAUSE_TWO] & enh_page;

	// Gated bits of a write are dropped while the enable bit is zero
	logic [7:0] int_en_in, q_ctl_in, mdm_ctl_in;
	logic       enh_drop;

	assign int_en_in  = ext_on ? wr_data_q
	                           : (wr_data_q & ~INTEN_EXT_MASK);
	assign q_ctl_in   = ext_on ? wr_data_q
	                           : (wr_data_q & ~QCTL_EXT_MASK);
	assign mdm_ctl_in = ext_on ? wr_data_q
	                           : (wr_data_q & ~MCTL_EXT_MASK);
	assign enh_drop   = wr_enh_feat & ~wr_data_q[ENH_ENABLE_BIT];

	// ************************************************************
	// Read multiplexer
	// ************************************************************
	logic [7:0] read_word [0:7];
	logic [7:0] read_value, int_en_view, int_st_view, mctl_view, mst_view;

	// Gated fields read as zero while extensions are off
	assign int_en_view = ext_on ? int_en
	                            : (int_en & ~INTEN_EXT_MASK);
	assign int_st_view = ext_on ? int_status_i
	                            : (int_status_i & ~INTST_EXT_MASK);
	assign mctl_view   = ext_on ? mdm_ctl
	                            : (mdm_ctl & ~MCTL_EXT_MASK);
	assign mst_view    = ext_on ? modem_status_i
	                            : (modem_status_i & ~MSTAT_EXT_MASK);

	// Extra feature and pulse width are write-only: no read path here
	assign read_word[OFS_HOLD] =
		base_page ? rx_data_i :
		div_page  ? (div_zero ? REVISION_VALUE : div_lo) :
		BYTE_ZERO;
	assign read_word[OFS_INTEN] =
		base_page ? int_en_view :
		div_page  ? (div_zero ? IDENT_VALUE : div_hi) :
		BYTE_ZERO;
	assign read_word[OFS_INTST] =
		base_page ? int_st_view :
		enh_page  ? enh_feat : BYTE_ZERO;
	assign read_word[OFS_LCTL] = line_ctl;
	assign read_word[OFS_MCTL] =
		base_page ? mctl_view :
		enh_page  ? res_one : BYTE_ZERO;
	assign read_word[OFS_LSTAT] =
		base_page ? line_status_i :
		enh_page  ? res_two : BYTE_ZERO;
	assign read_word[OFS_MSTAT] =
		base_page ? mst_view :
		enh_page  ? pau_one : BYTE_ZERO;
	assign read_word[OFS_SCRATCH] =
		base_page ? scratch :
		enh_page  ? pau_two : BYTE_ZERO;

	assign read_value = read_word[pins.addr];

	// ************************************************************
	// Strobe tracking
	// ************************************************************
	// Address and data are sampled while the write strobe is active, then held
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		wr_act_q  <= 1'b0;
		rd_act_q  <= 1'b0;
		wr_addr_q <= 3'h0;
		wr_data_q <= BYTE_ZERO;
	end
	else
	begin
		wr_act_q <= wr_act;
		rd_act_q <= rd_act;
		if (wr_act)
		begin
			wr_addr_q <= pins.addr;
			wr_data_q <= pins.data;
		end
	end

	// ************************************************************
	// Base page registers
	// ************************************************************
	// Clearing the enable bit also clears the gated bits it guards
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		int_en   <= INTEN_RESET;
		q_ctl    <= QCTL_RESET;
		line_ctl <= LCTL_RESET;
		mdm_ctl  <= MCTL_RESET;
		scratch  <= SCRATCH_RESET;
	end
	else
	begin
		if (wr_int_en)
			int_en <= int_en_in;
		else if (enh_drop)
			int_en <= int_en & ~INTEN_EXT_MASK;
		if (wr_q_ctl)
			q_ctl <= q_ctl_in;
		else if (enh_drop)
			q_ctl <= q_ctl & ~QCTL_EXT_MASK;
		if (wr_mdm_ctl)
			mdm_ctl <= mdm_ctl_in;
		else if (enh_drop)
			mdm_ctl <= mdm_ctl & ~MCTL_EXT_MASK;
		if (wr_line_ctl)
			line_ctl <= wr_data_q;
		if (wr_scratch)
			scratch <= wr_data_q;
	end

	// ************************************************************
	// Divisor and enhanced page registers
	// ************************************************************
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		div_lo   <= DIV_RESET;
		div_hi   <= DIV_RESET;
		enh_feat <= ENH_RESET;
		res_one  <= FLOW_CHAR_RESET;
		res_two  <= FLOW_CHAR_RESET;
		pau_one  <= FLOW_CHAR_RESET;
		pau_two  <= FLOW_CHAR_RESET;
	end
	else
	begin
		if (wr_div_lo)
			div_lo <= wr_data_q;
		if (wr_div_hi)
			div_hi <= wr_data_q;
		if (wr_enh_feat)
			enh_feat <= wr_data_q;
		if (wr_res_one)
			res_one <= wr_data_q;
		if (wr_res_two)
			res_two <= wr_data_q;
		if (wr_pau_one)
			pau_one <= wr_data_q;
		if (wr_pau_two)
			pau_two <= wr_data_q;
	end

	// ************************************************************
	// Write-only extension registers
	// ************************************************************
	// Contents stay put when the enable bit drops; the core must
	// qualify them with the enable bit itself
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		extra    <= EXTRA_RESET;
		ir_width <= IRWIDTH_RESET;
	end
	else
	begin
		if (wr_extra)
			extra <= wr_data_q;
		if (wr_ir_width)
			ir_width <= wr_data_q;
	end

	// ************************************************************
	// Access pulses and transmit byte
	// ************************************************************
	// Reads fire once at the start of the strobe, not every cycle
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		transmit_holding_o    <= BYTE_ZERO;
		transmit_write_o      <= 1'b0;
		queue_control_write_o <= 1'b0;
		receive_read_o        <= 1'b0;
		int_status_read_o     <= 1'b0;
		line_status_read_o    <= 1'b0;
		modem_status_read_o   <= 1'b0;
	end
	else
	begin
		if (wr_tx_hold)
			transmit_holding_o <= wr_data_q;
		transmit_write_o      <= wr_tx_hold;
		queue_control_write_o <= wr_q_ctl;
		receive_read_o        <= rd_start & base_page
		                         & (pins.addr == OFS_HOLD);
		int_status_read_o     <= rd_start & base_page
		                         & (pins.addr == OFS_INTST);
		line_status_read_o    <= rd_start & base_page
		                         & (pins.addr == OFS_LSTAT);
		modem_status_read_o   <= rd_start & base_page
		                         & (pins.addr == OFS_MSTAT);
	end

	// ************************************************************
	// Host data bus drive
	// ************************************************************
	// Enable is active low: the bus is driven while a read is active
	always_ff @(posedge clk_i)
	if (!rst_n_i)
	begin
		data_o      <= BYTE_ZERO;
		data_oe_n_o <= 1'b1;
	end
	else
	begin
		data_o      <= rd_act ? read_value : BYTE_ZERO;
		data_oe_n_o <= ~rd_act;
	end

	// ************************************************************
	// Register contents to the core
	// ************************************************************
	assign interrupt_enable_o     = int_en;
	assign queue_control_o        = q_ctl;
	assign line_control_o         = line_ctl;
	assign modem_control_o        = mdm_ctl;
	assign scratch_pad_o          = scratch;
	assign baud_divisor_low_o     = div_lo;
	assign baud_divisor_high_o    = div_hi;
	assign enhanced_feature_o     = enh_feat;
	assign resume_char_one_o      = res_one;
	assign resume_char_two_o      = res_two;
	assign pause_char_one_o       = pau_one;
	assign pause_char_two_o       = pau_two;
	assign extra_feature_o        = extra;
	assign infrared_pulse_width_o = ir_width;

endmodule

`default_nettype wire

// *** rtl/uart_regs_pkg.sv ***
/*
 * Constants of the UART register map: offsets of the eight locations,
 * field positions, masks of the enhanced-gated bits, reset values and
 * the page key.
 * Assumes an 8-bit host bus with three address lines.
 */
`default_nettype none

package uart_regs_pkg;

	// ************************************************************
	// Bus widths
	// ************************************************************
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int PIN_W  = 14; // Select, read, write, address, data

	// ************************************************************
	// Register offsets (A2..A0)
	// ************************************************************
	localparam logic [2:0] OFS_HOLD        = 3'h0;
	localparam logic [2:0] OFS_DIV_LOW     = 3'h0;
	localparam logic [2:0] OFS_INTEN       = 3'h1;
	localparam logic [2:0] OFS_DIV_HIGH    = 3'h1;
	localparam logic [2:0] OFS_INTST       = 3'h2;
	localparam logic [2:0] OFS_ENH         = 3'h2;
	localparam logic [2:0] OFS_LCTL        = 3'h3;
	localparam logic [2:0] OFS_MCTL        = 3'h4;
	localparam logic [2:0] OFS_RESUME_ONE  = 3'h4;
	localparam logic [2:0] OFS_LSTAT       = 3'h5;
	localparam logic [2:0] OFS_RESUME_TWO  = 3'h5;
	localparam logic [2:0] OFS_MSTAT       = 3'h6;
	localparam logic [2:0] OFS_PAUSE_ONE   = 3'h6;
	localparam logic [2:0] OFS_SCRATCH     = 3'h7;
	localparam logic [2:0] OFS_PAUSE_TWO   = 3'h7;

	// ************************************************************
	// Fields, page key and gated bit masks
	// ************************************************************
	localparam int         DIV_ACCESS_BIT  = 7;
	localparam int         ENH_ENABLE_BIT  = 4;
	localparam logic [7:0] ENH_PAGE_KEY    = 8'hbf;
	localparam logic [7:0] INTEN_EXT_MASK  = 8'hf0;
	localparam logic [7:0] INTST_EXT_MASK  = 8'h30;
	localparam logic [7:0] QCTL_EXT_MASK   = 8'h30;
	localparam logic [7:0] MCTL_EXT_MASK   = 8'he0;
	localparam logic [7:0] MSTAT_EXT_MASK  = 8'hf0;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] INTEN_RESET     = 8'h00;
	localparam logic [7:0] QCTL_RESET      = 8'h00;
	localparam logic [7:0] LCTL_RESET      = 8'h00;
	localparam logic [7:0] MCTL_RESET      = 8'h00;
	localparam logic [7:0] SCRATCH_RESET   = 8'h00;
	localparam logic [7:0] DIV_RESET       = 8'h00;
	localparam logic [7:0] ENH_RESET       = 8'h00;
	localparam logic [7:0] FLOW_CHAR_RESET = 8'h00;
	localparam logic [7:0] EXTRA_RESET     = 8'h00;
	localparam logic [7:0] IRWIDTH_RESET   = 8'h00;

	// ************************************************************
	// Identity codes (values arbitrary)
	// ************************************************************
	localparam logic [7:0] REVISION_VALUE  = 8'h01; // Arbitrary value
	localparam logic [7:0] IDENT_VALUE     = 8'h5a; // Arbitrary value

endpackage

`default_nettype wire
